// ===== charger_control_register_bank.sv
// charger control and status register bank with detection, limits, timers and interrupt
// What this block does
// - status mask bits of one block their interrupt, zero passes it; boost mask bits are read-only and stay 0.
// - detected adapter class is reported in a read-only three-bit field.
// - limit select picks class, average setting, the higher or the lower of both.
// - secondary detection runs only while its enable bit is one.
// - primary detection starts on plug-in when enabled; host restarts by toggling 0 then 1.
// - read-only running flag is one exactly while detection is in progress.
// - power-path source bit gives the pin to software at 0, hardware at 1.
// - under software control drive 0 pulls the pin high, 1 pulls it low.
// - minimum-input regulation disable bit: 0 keeps regulation on, 1 turns it off.
// - four-bit level field selects minimum input voltage, 4.0 V to 15.5 V.
// - writing 1 releases the 0.6 V data-line source; status bit then reads 1.
// - three-bit fast-charge timeout field, 4 to 16 hours in two-hour steps.
// - two-bit precharge timeout field, 30, 45 or 60 minutes.
// - hold bit freezes the charge safety timers while one.
// - five-bit average input limit decodes 100, 150, 500 mA, 100 mA steps, or off.
// - three-bit dead-battery threshold, 2.9 V to 3.6 V in 0.1 V steps.
// - two-bit end-of-charge timer field, 0, 30, 45 or 60 minutes.
// - enabled wake-up timer raises a periodic interrupt, 4 s to 8 min.
// - host writes 1 to release the interrupt; the bit clears itself afterwards.
// - watchdog off and reset at 0; at 1 it expires after 1 to 8 s.
// - each temperature region flag sets when the sensed zone enters or leaves it.
// - power-good flag sets on every change of input power state.
// - input-loop flag sets whenever the minimum-input loop changes state.
// - with limit source 0 the boost-select pin gives 500 mA low, 1 A high.
`timescale 1ns/1ps
`default_nettype none
module charger_control_register_bank #(
	parameter int TICK_CYCLES = charger_regs_pkg::TICK_CYCLES_DEFAULT
) (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic ce,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	input wire logic vin_present,
	input wire logic detect_done,
	input wire logic [2:0] detect_class,
	input wire logic boost_select_pin,
	input wire logic input_limit_source,
	input wire logic hw_power_path,
	input wire charger_regs_pkg::status_levels_t status_levels,
	input wire logic [2:0] boost_fault_event,
	output logic irq_n,
	output logic detect_start,
	output logic secondary_detect_active,
	output logic [11:0] input_limit_ma,
	output logic power_path_pin,
	output logic min_input_reg_enable,
	output logic [3:0] min_input_reg_level,
	output logic data_line_source_enable,
	output logic [2:0] fast_charge_timeout,
	output logic [1:0] precharge_timeout,
	output logic safety_timer_hold,
	output logic [2:0] dead_battery_threshold,
	output logic [1:0] eoc_timer,
	output logic wakeup_expired,
	output logic watchdog_expired
);
	localparam logic [charger_regs_pkg::TICK_W-1:0] TICK_LAST =
		charger_regs_pkg::TICK_W'(TICK_CYCLES - 1);

	typedef struct packed {
		charger_regs_pkg::boost_mask_t bmask;
		charger_regs_pkg::adapter_ctrl_t adc;
		charger_regs_pkg::power_path_t pp;
		charger_regs_pkg::data_line_t dl;
		charger_regs_pkg::input_limit_t il;
		charger_regs_pkg::wakeup_irq_t ew;
		charger_regs_pkg::watchdog_t wd;
		charger_regs_pkg::stat_t smask;
		logic [7:0] rdata;
		charger_regs_pkg::det_state_t det;
		logic vin_q;
		logic pri_q;
		logic [charger_regs_pkg::TICK_W-1:0] tick_cnt;
		logic tick;
		logic irq_n;
		logic dstart;
		logic sec_active;
		logic [11:0] limit;
		logic pp_pin;
	} state_t;

	localparam state_t ST_RESET = '{
		bmask: charger_regs_pkg::BOOST_MASK_RESET,
		adc: charger_regs_pkg::ADAPTER_RESET,
		pp: charger_regs_pkg::POWER_PATH_RESET,
		dl: charger_regs_pkg::DATA_LINE_RESET,
		il: charger_regs_pkg::INPUT_LIMIT_RESET,
		ew: charger_regs_pkg::WAKEUP_IRQ_RESET,
		wd: charger_regs_pkg::WATCHDOG_RESET,
		smask: charger_regs_pkg::STAT_MASK_RESET,
		det: charger_regs_pkg::DET_IDLE,
		pri_q: 1'b1,
		irq_n: 1'b1,
		pp_pin: 1'b1,
		limit: charger_regs_pkg::LIMIT_500MA,
		default: '0
	};

	logic [1:0] rst_sync;
	logic rst_n;
	state_t st, nx;
	logic [charger_regs_pkg::NUM_STAT_FLAGS-1:0] flags, flag_set, levels;
	logic rd_flags, start, unmasked_event;
	logic [11:0] avg_ma, cls_ma;
	logic wake_exp, wd_exp, wake_restart;
	charger_regs_pkg::data_line_t dl_w;
	charger_regs_pkg::wakeup_irq_t ew_w;

	// reset release through two flops; assertion stays asynchronous
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) rst_sync <= 2'h0;
		else rst_sync <= {rst_sync[0], 1'b1};
	end
	assign rst_n = rst_sync[1];

	// one change detector per status flag, cleared by reading the flags
	assign levels = status_levels;
	assign rd_flags = reg_rd && (reg_addr == charger_regs_pkg::ADDR_STAT_FLAGS);
	for (genvar i = 0; i < charger_regs_pkg::NUM_STAT_FLAGS; i++) begin : g_flag
		status_change_flag u_flag (
			.clk(clk),
			.rst_n(rst_n),
			.ce(ce),
			.level(levels[i]),
			.clear(rd_flags),
			.flag(flags[i]),
			.set_pulse(flag_set[i])
		);
	end

	// wake-up period restarts whenever its register is rewritten
	assign wake_restart = reg_wr && (reg_addr == charger_regs_pkg::ADDR_WAKEUP_IRQ);
	period_timer u_wake (
		.clk(clk),
		.rst_n(rst_n),
		.ce(ce),
		.enable(st.ew.wakeup_timer_enable),
		.restart(wake_restart),
		.tick(st.tick),
		.limit(charger_regs_pkg::WAKE_S[st.ew.wakeup_period]),
		.expire(wake_exp)
	);

	// any register write kicks the watchdog
	period_timer u_watchdog (
		.clk(clk),
		.rst_n(rst_n),
		.ce(ce),
		.enable(st.wd.watchdog_enable),
		.restart(reg_wr),
		.tick(st.tick),
		.limit(charger_regs_pkg::WATCHDOG_S[st.wd.watchdog_period]),
		.expire(wd_exp)
	);

	// limit sources for the selector
	assign avg_ma = charger_regs_pkg::avg_limit_ma(st.il.avg_input_current_limit);
	assign cls_ma = charger_regs_pkg::CLASS_LIMIT[st.adc.adapter_class];
	assign dl_w = reg_wdata;
	assign ew_w = reg_wdata;
	assign start = st.adc.primary_detect_enable && vin_present &&
		(!st.vin_q || !st.pri_q);

	always_comb begin
		nx = st;
		nx.tick = 1'b0;
		nx.dstart = 1'b0;
		nx.vin_q = vin_present;
		nx.pri_q = st.adc.primary_detect_enable;
		// base tick prescaler; a long count, shortened in simulation by parameter
		if (st.tick_cnt == TICK_LAST) begin
			nx.tick_cnt = '0;
			nx.tick = 1'b1;
		end else begin
			nx.tick_cnt = st.tick_cnt + 1'b1;
		end
		// release completes in one cycle, then the bit drops by itself
		if (st.ew.interrupt_release) nx.ew.interrupt_release = 1'b0;
		// register writes; the boost mask register is read-only and stays at reset
		if (reg_wr) begin
			if (reg_addr == charger_regs_pkg::ADDR_ADAPTER) begin
				nx.adc = (reg_wdata & charger_regs_pkg::ADAPTER_WR_MASK) |
					(st.adc & ~charger_regs_pkg::ADAPTER_WR_MASK);
			end else if (reg_addr == charger_regs_pkg::ADDR_POWER_PATH) begin
				nx.pp = reg_wdata;
			end else if (reg_addr == charger_regs_pkg::ADDR_DATA_LINE) begin
				nx.dl = (reg_wdata & charger_regs_pkg::DATA_LINE_WR_MASK) |
					(st.dl & ~charger_regs_pkg::DATA_LINE_WR_MASK);
				// writing 0 leaves an earlier release in place
				nx.dl.data_line_source_state = st.dl.data_line_source_state |
					dl_w.data_line_release;
			end else if (reg_addr == charger_regs_pkg::ADDR_INPUT_LIMIT) begin
				nx.il = reg_wdata;
			end else if (reg_addr == charger_regs_pkg::ADDR_WAKEUP_IRQ) begin
				nx.ew = reg_wdata;
				nx.ew.interrupt_release = ew_w.interrupt_release;
			end else if (reg_addr == charger_regs_pkg::ADDR_WATCHDOG) begin
				nx.wd = reg_wdata;
			end else if (reg_addr == charger_regs_pkg::ADDR_STAT_MASK) begin
				nx.smask = reg_wdata;
			end
		end
		// adapter detection sequencer
		case (st.det)
			charger_regs_pkg::DET_IDLE, charger_regs_pkg::DET_DONE: begin
				if (start) begin
					nx.det = charger_regs_pkg::DET_RUN;
					nx.dstart = 1'b1;
				end
			end
			charger_regs_pkg::DET_RUN: begin
				if (!st.adc.primary_detect_enable || !vin_present) begin
					nx.det = charger_regs_pkg::DET_IDLE;
				end else if (detect_done) begin
					nx.det = charger_regs_pkg::DET_DONE;
					nx.adc.adapter_class = detect_class;
				end
			end
			default: nx.det = charger_regs_pkg::DET_IDLE;
		endcase
		// class of a removed adapter is no longer valid
		if (!vin_present) nx.adc.adapter_class = '0;
		nx.adc.detect_running = (nx.det == charger_regs_pkg::DET_RUN);
		nx.sec_active = nx.adc.detect_running && nx.adc.secondary_detect_enable;
		// effective input current limit
		if (!input_limit_source) begin
			nx.limit = boost_select_pin ? charger_regs_pkg::LIMIT_1A :
				charger_regs_pkg::LIMIT_500MA;
		end else begin
			case (st.adc.input_limit_select)
				charger_regs_pkg::SEL_CLASS: nx.limit = cls_ma;
				charger_regs_pkg::SEL_AVG: nx.limit = avg_ma;
				charger_regs_pkg::SEL_HIGHER: nx.limit = (avg_ma > cls_ma) ? avg_ma : cls_ma;
				default: nx.limit = (avg_ma < cls_ma) ? avg_ma : cls_ma;
			endcase
		end
		// power-path pin: drive bit 1 pulls low, so the level is its inverse
		nx.pp_pin = st.pp.power_path_source_select ? hw_power_path :
			!st.pp.power_path_drive;
		// registered read data, zero for unmapped addresses
		if (reg_rd) begin
			if (reg_addr == charger_regs_pkg::ADDR_BOOST_MASK) nx.rdata = st.bmask;
			else if (reg_addr == charger_regs_pkg::ADDR_ADAPTER) nx.rdata = st.adc;
			else if (reg_addr == charger_regs_pkg::ADDR_POWER_PATH) nx.rdata = st.pp;
			else if (reg_addr == charger_regs_pkg::ADDR_DATA_LINE) nx.rdata = st.dl;
			else if (reg_addr == charger_regs_pkg::ADDR_INPUT_LIMIT) nx.rdata = st.il;
			else if (reg_addr == charger_regs_pkg::ADDR_WAKEUP_IRQ) nx.rdata = st.ew;
			else if (reg_addr == charger_regs_pkg::ADDR_WATCHDOG) nx.rdata = st.wd;
			else if (reg_addr == charger_regs_pkg::ADDR_STAT_FLAGS) begin
				nx.rdata = {flags, charger_regs_pkg::STAT_RESERVED};
			end else if (reg_addr == charger_regs_pkg::ADDR_STAT_MASK) nx.rdata = st.smask;
			else nx.rdata = charger_regs_pkg::READ_ZERO;
		end
		// a new unmasked event wins over a release or a flag read in the same cycle
		if (unmasked_event) nx.irq_n = 1'b0;
		else if (st.ew.interrupt_release || rd_flags) nx.irq_n = 1'b1;
	end

	// status masks gate their flags; boost masks gate the boost fault events
	always_comb begin
		unmasked_event = |(flag_set & ~st.smask[7:2]) ||
			|(boost_fault_event & ~st.bmask[7:5]) || wake_exp || wd_exp;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) st <= ST_RESET;
		else if (ce) st <= nx;
	end

	// outputs straight from the state flops
	assign reg_rdata = st.rdata;
	assign irq_n = st.irq_n;
	assign detect_start = st.dstart;
	assign secondary_detect_active = st.sec_active;
	assign input_limit_ma = st.limit;
	assign power_path_pin = st.pp_pin;
	assign min_input_reg_enable = !st.pp.min_input_reg_disable;
	assign min_input_reg_level = st.pp.min_input_reg_level;
	assign data_line_source_enable = !st.dl.data_line_source_state;
	assign fast_charge_timeout = st.dl.fast_charge_timeout;
	assign precharge_timeout = st.dl.precharge_timeout;
	assign safety_timer_hold = st.dl.safety_timer_hold;
	assign dead_battery_threshold = st.il.dead_battery_threshold;
	assign eoc_timer = st.ew.eoc_timer;
	assign wakeup_expired = wake_exp;
	assign watchdog_expired = wd_exp;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n || !ce);

	sequence s_release_write;
		reg_wr && reg_addr == charger_regs_pkg::ADDR_WAKEUP_IRQ && reg_wdata[0];
	endsequence

	a_boost_mask_reads: assert property (reg_rd && reg_addr == charger_regs_pkg::ADDR_BOOST_MASK
		|=> reg_rdata == charger_regs_pkg::BOOST_MASK_RESET) else $error("boost mask not zero");
	a_masked_stays_quiet: assert property (irq_n && !unmasked_event |=> irq_n)
		else $error("interrupt without unmasked event");
	a_event_raises_irq: assert property (unmasked_event |=> !irq_n)
		else $error("unmasked event did not raise interrupt");
	a_limit_from_pin: assert property (!input_limit_source && boost_select_pin
		|=> input_limit_ma == charger_regs_pkg::LIMIT_1A) else $error("pin limit not 1 A");
	a_limit_lower: assert property (input_limit_source && st.adc.input_limit_select ==
		charger_regs_pkg::SEL_LOWER |=> input_limit_ma <= $past(avg_ma))
		else $error("lower limit exceeds average setting");
	a_sw_path_level: assert property (!st.pp.power_path_source_select
		|=> power_path_pin == !$past(st.pp.power_path_drive)) else $error("power path level wrong");
	a_release_clears: assert property (st.ew.interrupt_release && !(reg_wr && reg_wdata[0] &&
		reg_addr == charger_regs_pkg::ADDR_WAKEUP_IRQ) |=> !st.ew.interrupt_release)
		else $error("release bit did not clear");
	a_release_frees: assert property (!irq_n ##0 s_release_write ##1 !unmasked_event [*2]
		|=> irq_n) else $error("release did not free interrupt");
	a_data_line_free: assert property (reg_wr && reg_addr == charger_regs_pkg::ADDR_DATA_LINE &&
		reg_wdata[7] |=> !data_line_source_enable ##1 st.dl.data_line_source_state)
		else $error("data line not released");
	a_detect_runs: assert property (start && st.det != charger_regs_pkg::DET_RUN
		|=> st.adc.detect_running && detect_start) else $error("detection did not start");

	// flag reads, class capture, limit bounds and pin levels
	a_flag_read_frees: assert property (rd_flags && !unmasked_event |=> irq_n)
		else $error("flag read did not free interrupt");
	a_class_latched: assert property (st.det == charger_regs_pkg::DET_RUN && detect_done
		&& vin_present && st.adc.primary_detect_enable
		|=> st.adc.adapter_class == $past(detect_class)) else $error("class not stored");
	a_done_stops: assert property (st.det == charger_regs_pkg::DET_RUN && detect_done
		|=> !st.adc.detect_running) else $error("running flag stayed after done");
	a_limit_higher: assert property (input_limit_source && st.adc.input_limit_select ==
		charger_regs_pkg::SEL_HIGHER |=> input_limit_ma >= $past(avg_ma))
		else $error("higher limit below average setting");
	a_line_sticky: assert property (!data_line_source_enable
		|=> !data_line_source_enable) else $error("data line source came back");
	a_hw_path_level: assert property (st.pp.power_path_source_select
		|=> power_path_pin == $past(hw_power_path)) else $error("hardware path level wrong");
endmodule : charger_control_register_bank
`default_nettype wire

// ===== charger_regs_pkg.sv
// register map, field layouts, reset values and timing constants of the charger register bank
package charger_regs_pkg;

	// register byte addresses
	localparam logic [7:0] ADDR_BOOST_MASK = 8'h0D;
	localparam logic [7:0] ADDR_ADAPTER = 8'h0E;
	localparam logic [7:0] ADDR_POWER_PATH = 8'h21;
	localparam logic [7:0] ADDR_DATA_LINE = 8'h22;
	localparam logic [7:0] ADDR_INPUT_LIMIT = 8'h23;
	localparam logic [7:0] ADDR_WAKEUP_IRQ = 8'h24;
	localparam logic [7:0] ADDR_WATCHDOG = 8'h25;
	localparam logic [7:0] ADDR_STAT_FLAGS = 8'h26;
	localparam logic [7:0] ADDR_STAT_MASK = 8'h27;

	// field layouts, msb first
	typedef struct packed {
		logic boost_input_ovp_mask;
		logic boost_overload_mask;
		logic boost_low_battery_mask;
		logic [4:0] reserved;
	} boost_mask_t;
	typedef struct packed {
		logic [2:0] adapter_class;
		logic [1:0] input_limit_select;
		logic secondary_detect_enable;
		logic primary_detect_enable;
		logic detect_running;
	} adapter_ctrl_t;
	typedef struct packed {
		logic reserved;
		logic power_path_source_select;
		logic power_path_drive;
		logic min_input_reg_disable;
		logic [3:0] min_input_reg_level;
	} power_path_t;
	typedef struct packed {
		logic data_line_release;
		logic data_line_source_state;
		logic [2:0] fast_charge_timeout;
		logic [1:0] precharge_timeout;
		logic safety_timer_hold;
	} data_line_t;
	typedef struct packed {
		logic [4:0] avg_input_current_limit;
		logic [2:0] dead_battery_threshold;
	} input_limit_t;
	typedef struct packed {
		logic [1:0] eoc_timer;
		logic [2:0] wakeup_period;
		logic wakeup_timer_enable;
		logic interrupt_pulse_enable;
		logic interrupt_release;
	} wakeup_irq_t;
	typedef struct packed {
		logic watchdog_enable;
		logic [1:0] reserved_hi;
		logic bus_reset_wait;
		logic [1:0] reserved_lo;
		logic [1:0] watchdog_period;
	} watchdog_t;
	// same layout for flags and their masks
	typedef struct packed {
		logic temp_hot_change_flag;
		logic temp_warm_change_flag;
		logic temp_cool_change_flag;
		logic temp_cold_change_flag;
		logic power_good_change_flag;
		logic input_loop_change_flag;
		logic [1:0] reserved;
	} stat_t;
	// sensed levels whose changes raise the status flags
	typedef struct packed {
		logic temp_hot;
		logic temp_warm;
		logic temp_cool;
		logic temp_cold;
		logic power_good;
		logic min_input_voltage_loop;
	} status_levels_t;

	localparam int NUM_STAT_FLAGS = 6;
	localparam logic [1:0] STAT_RESERVED = 2'h0;

	// reset values and writable bit masks
	localparam logic [7:0] BOOST_MASK_RESET = 8'h00;
	localparam logic [7:0] ADAPTER_RESET = 8'h16;
	localparam logic [7:0] ADAPTER_WR_MASK = 8'h1E;
	localparam logic [7:0] POWER_PATH_RESET = 8'h40;
	localparam logic [7:0] DATA_LINE_RESET = 8'h00;
	localparam logic [7:0] DATA_LINE_WR_MASK = 8'hBF;
	localparam logic [7:0] INPUT_LIMIT_RESET = 8'h2F;
	localparam logic [7:0] WAKEUP_IRQ_RESET = 8'h00;
	localparam logic [7:0] WATCHDOG_RESET = 8'h13;
	localparam logic [7:0] STAT_MASK_RESET = 8'h00;
	localparam logic [7:0] READ_ZERO = 8'h00;

	// detection sequencer states
	typedef enum logic [2:0] {
		DET_IDLE = 3'b001,
		DET_RUN = 3'b010,
		DET_DONE = 3'b100
	} det_state_t;

	// input limit source selections
	localparam logic [1:0] SEL_CLASS = 2'h0;
	localparam logic [1:0] SEL_AVG = 2'h1;
	localparam logic [1:0] SEL_HIGHER = 2'h2;
	localparam logic [1:0] SEL_LOWER = 2'h3;

	// input current limits in mA
	localparam logic [11:0] LIMIT_100MA = 12'h064;
	localparam logic [11:0] LIMIT_150MA = 12'h096;
	localparam logic [11:0] LIMIT_500MA = 12'h1F4;
	localparam logic [11:0] LIMIT_1A = 12'h3E8;
	localparam logic [11:0] LIMIT_1500MA = 12'h5DC;
	localparam logic [11:0] LIMIT_NONE = 12'hFFF;
	localparam logic [11:0] LIMIT_STEP = 12'h064;
	localparam logic [4:0] AVG_DISABLE = 5'h1F;
	localparam logic [3:0] AVG_CODE_100 = 4'h0;
	localparam logic [3:0] AVG_CODE_150 = 4'h1;
	localparam logic [3:0] AVG_CODE_500 = 4'h2;
	localparam logic [11:0] CLASS_LIMIT [8] = '{LIMIT_500MA, LIMIT_1A, LIMIT_500MA, LIMIT_1A,
		LIMIT_1A, LIMIT_1A, LIMIT_1500MA, LIMIT_1500MA};

	// timing: one base tick per second
	localparam int CLK_HZ = 200_000_000;
	localparam int TICK_S = 1;
	localparam int TICK_CYCLES_DEFAULT = TICK_S * CLK_HZ;
	localparam int TICK_W = 28;
	localparam int TIMER_W = 9;
	localparam logic [8:0] WAKE_S [8] = '{9'h004, 9'h008, 9'h010, 9'h020, 9'h040, 9'h078,
		9'h0F0, 9'h1E0};
	localparam logic [8:0] WATCHDOG_S [4] = '{9'h001, 9'h002, 9'h004, 9'h008};

	// average input current limit decode in mA
	function automatic logic [11:0] avg_limit_ma(input logic [4:0] code);
		if (code == AVG_DISABLE) return LIMIT_NONE;
		else if (code[4:1] == AVG_CODE_100) return LIMIT_100MA;
		else if (code[4:1] == AVG_CODE_150) return LIMIT_150MA;
		else if (code[4:1] == AVG_CODE_500) return LIMIT_500MA;
		else return 12'({7'h00, code} * LIMIT_STEP);
	endfunction : avg_limit_ma

endpackage : charger_regs_pkg

// ===== status_change_flag.sv
// sticky flag that sets on every change of a sensed level
`timescale 1ns/1ps
`default_nettype none
module status_change_flag (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic level,
	input wire logic clear,
	output logic flag,
	output logic set_pulse
);
	typedef struct packed {
		logic armed;
		logic prev;
		logic flag;
	} flag_state_t;
	flag_state_t st, nx;

	// first cycle after reset only learns the level, so a high strap raises nothing
	always_comb begin
		nx = st;
		set_pulse = st.armed && (level != st.prev);
		nx.armed = 1'b1;
		nx.prev = level;
		if (set_pulse) nx.flag = 1'b1;
		else if (clear) nx.flag = 1'b0;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) st <= '0;
		else if (ce) st <= nx;
	end

	assign flag = st.flag;

	// a change in the clearing cycle still leaves the flag set
	a_change_sets_flag: assert property (@(posedge clk) disable iff (!rst_n || !ce)
		set_pulse |=> flag) else $error("level change did not set flag");
endmodule : status_change_flag
`default_nettype wire

// ===== period_timer.sv
// second-tick counter that pulses when a programmed number of ticks has passed
`timescale 1ns/1ps
`default_nettype none
module period_timer (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic enable,
	input wire logic restart,
	input wire logic tick,
	input wire logic [charger_regs_pkg::TIMER_W-1:0] limit,
	output logic expire
);
	typedef struct packed {
		logic [charger_regs_pkg::TIMER_W-1:0] count;
		logic expire;
	} timer_state_t;
	timer_state_t st, nx;

	// disabled or restarted timers hold at zero; expiry restarts the period
	always_comb begin
		nx = st;
		nx.expire = 1'b0;
		if (!enable || restart) begin
			nx.count = '0;
		end else if (tick) begin
			if (st.count + 1'b1 >= limit) begin
				nx.count = '0;
				nx.expire = 1'b1;
			end else begin
				nx.count = st.count + 1'b1;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) st <= '0;
		else if (ce) st <= nx;
	end

	assign expire = st.expire;

	a_off_no_expire: assert property (@(posedge clk) disable iff (!rst_n || !ce)
		(!enable) [*2] |-> !expire) else $error("disabled timer expired");
endmodule : period_timer
`default_nettype wire

// ===== host_model.sv
// host-side model driving the register strobe port
`timescale 1ns/1ps
`default_nettype none
module host_model (
	input wire logic clk,
	input wire logic [7:0] reg_rdata,
	output logic reg_wr,
	output logic reg_rd,
	output logic [7:0] reg_addr,
	output logic [7:0] reg_wdata
);
	// idle bus at time zero
	initial begin
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
	end
	// one-cycle strobe; address and data flipped after release so stale values never match
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		#1;
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(posedge clk);
		#1;
		reg_wr = 1'b0;
		reg_addr = ~a;
		reg_wdata = ~d;
	endtask : wr
	// read data is registered at the edge that takes the strobe
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk);
		#1;
		reg_addr = a;
		reg_rd = 1'b1;
		@(posedge clk);
		#1;
		reg_rd = 1'b0;
		reg_addr = ~a;
		d = reg_rdata;
	endtask : rd
endmodule : host_model
`default_nettype wire

// ===== tb_top.sv
// self-checking bench for the charger register bank
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic clk, arst_n, reg_wr, reg_rd, vin_present, detect_done, boost_select_pin;
	logic input_limit_source, hw_power_path, irq_n, sec_active, pp_pin, mir_en;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, rv;
	logic [2:0] detect_class, fct, dbt, bfe;
	logic [1:0] pct, eoc;
	logic [3:0] mir_lvl;
	logic dstart, dl_en, hold, wd_exp, wk_exp;
	logic [11:0] limit_ma;
	charger_regs_pkg::status_levels_t lv;
	int n_mismatch = 0;
	int cmp_count = 0;
	host_model host (.clk(clk), .reg_rdata(reg_rdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata));
	charger_control_register_bank #(.TICK_CYCLES(20)) dut (.clk(clk), .arst_n(arst_n), .ce(1'b1),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata), .vin_present(vin_present), .detect_done(detect_done),
		.detect_class(detect_class), .boost_select_pin(boost_select_pin),
		.input_limit_source(input_limit_source), .hw_power_path(hw_power_path),
		.status_levels(lv), .boost_fault_event(bfe), .irq_n(irq_n), .detect_start(dstart),
		.secondary_detect_active(sec_active), .input_limit_ma(limit_ma),
		.power_path_pin(pp_pin), .min_input_reg_enable(mir_en), .min_input_reg_level(mir_lvl),
		.data_line_source_enable(dl_en), .fast_charge_timeout(fct), .precharge_timeout(pct),
		.safety_timer_hold(hold), .dead_battery_threshold(dbt), .eoc_timer(eoc),
		.wakeup_expired(wk_exp), .watchdog_expired(wd_exp));
	// 200 MHz clock
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	task automatic chk(input logic [11:0] got, input logic [11:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask : chk
	// registered outputs need a couple of edges after the cause
	task automatic settle();
		repeat (3) @(posedge clk);
		#1;
	endtask : settle
	task automatic reset_values();
		logic [7:0] ad [6] = '{8'h0D, 8'h0E, 8'h21, 8'h23, 8'h25, 8'h27};
		logic [7:0] ex [6] = '{8'h00, 8'h16, 8'h40, 8'h2F, 8'h13, 8'h00};
		for (int i = 0; i < 6; i++) begin
			host.rd(ad[i], rv);
			chk(rv, ex[i]);
		end
		host.wr(8'h0D, 8'hFF);
		host.rd(8'h0D, rv);
		chk(rv, 8'h00);
	endtask : reset_values
	task automatic detection();
		vin_present = 1'b1;
		@(posedge clk);
		#1;
		chk(dstart, 1'b1);
		settle();
		host.rd(8'h0E, rv);
		chk(rv, 8'h17);
		chk(sec_active, 1'b1);
		detect_class = 3'h3;
		detect_done = 1'b1;
		@(posedge clk);
		#1;
		detect_done = 1'b0;
		host.rd(8'h0E, rv);
		chk(rv, 8'h76);
		host.wr(8'h0E, 8'h14);
		host.wr(8'h0E, 8'h16);
		settle();
		host.rd(8'h0E, rv);
		chk(rv[0], 1'b1);
		detect_class = 3'h0;
		detect_done = 1'b1;
		@(posedge clk);
		#1;
		detect_done = 1'b0;
	endtask : detection
	task automatic limits();
		settle();
		chk(limit_ma, 12'h1F4);
		boost_select_pin = 1'b1;
		settle();
		chk(limit_ma, 12'h3E8);
		input_limit_source = 1'b1;
		host.wr(8'h23, 8'hF3);
		host.wr(8'h0E, 8'h0A);
		settle();
		chk(limit_ma, 12'hBB8);
		chk(dbt, 3'h3);
		host.wr(8'h0E, 8'h12);
		settle();
		chk(limit_ma, 12'hBB8);
		host.wr(8'h0E, 8'h1A);
		settle();
		chk(limit_ma, 12'h1F4);
	endtask : limits
	task automatic power_path();
		host.wr(8'h21, 8'h00);
		settle();
		chk(pp_pin, 1'b1);
		host.wr(8'h21, 8'h3F);
		settle();
		chk(pp_pin, 1'b0);
		chk(mir_en, 1'b0);
		chk(mir_lvl, 4'hF);
		hw_power_path = 1'b1;
		host.wr(8'h21, 8'h60);
		settle();
		chk(pp_pin, 1'b1);
	endtask : power_path
	task automatic status_irq();
		lv.power_good = 1'b1;
		settle();
		chk(irq_n, 1'b0);
		host.rd(8'h26, rv);
		chk(rv, 8'h08);
		settle();
		chk(irq_n, 1'b1);
		lv.power_good = 1'b0;
		settle();
		host.wr(8'h24, 8'h01);
		settle();
		chk(irq_n, 1'b1);
		host.rd(8'h24, rv);
		chk(rv, 8'h00);
		host.rd(8'h26, rv);
		chk(rv, 8'h08);
		host.wr(8'h27, 8'h08);
		lv.power_good = 1'b1;
		settle();
		chk(irq_n, 1'b1);
		lv.min_input_voltage_loop = 1'b1;
		settle();
		chk(irq_n, 1'b0);
		host.rd(8'h26, rv);
		chk(rv, 8'h0C);
		lv.temp_hot = 1'b1;
		settle();
		host.rd(8'h26, rv);
		chk(rv, 8'h80);
		bfe = 3'h4;
		@(posedge clk);
		#1;
		bfe = 3'h0;
		settle();
		chk(irq_n, 1'b0);
		host.rd(8'h26, rv);
	endtask : status_irq
	task automatic data_line();
		chk(dl_en, 1'b1);
		host.wr(8'h22, 8'h8F);
		host.rd(8'h22, rv);
		chk(rv, 8'hCF);
		chk(dl_en, 1'b0);
		chk({fct, pct, hold}, 12'h00F);
		host.wr(8'h22, 8'h00);
		host.rd(8'h22, rv);
		chk(rv, 8'h40);
	endtask : data_line
	// watchdog on, then off while the wake-up timer runs
	task automatic timers();
		logic wd_seen, wk_seen;
		host.wr(8'h25, 8'h80);
		wd_seen = 1'b0;
		repeat (30) begin
			@(posedge clk);
			#1;
			wd_seen |= wd_exp;
		end
		chk(wd_seen, 1'b1);
		chk(irq_n, 1'b0);
		host.wr(8'h25, 8'h13);
		host.wr(8'h24, 8'hC4);
		{wd_seen, wk_seen} = 2'h0;
		repeat (100) begin
			@(posedge clk);
			#1;
			wd_seen |= wd_exp;
			wk_seen |= wk_exp;
		end
		chk(wd_seen, 1'b0);
		chk(wk_seen, 1'b1);
		chk(eoc, 2'h3);
	endtask : timers
	task automatic finish_test();
		if (n_mismatch == 0 && cmp_count > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : finish_test
	// main sequence: reset held six cycles, then each scenario
	initial begin
		arst_n = 1'b0;
		{vin_present, detect_done, boost_select_pin, input_limit_source, hw_power_path} = 5'h00;
		detect_class = 3'h0;
		bfe = 3'h0;
		lv = '0;
		repeat (6) @(posedge clk);
		#1;
		arst_n = 1'b1;
		repeat (4) @(posedge clk);
		reset_values();
		detection();
		limits();
		power_path();
		status_irq();
		data_line();
		timers();
		finish_test();
	end
	// hang guard, far beyond the few hundred cycles the scenarios need
	initial begin
		#20000;
		n_mismatch++;
		finish_test();
	end
endmodule : tb_top
`default_nettype wire
